// ### logic/debug_lock_and_boot_fuses.sv
/*
 * Boot fuse decode and debug-port access lock, with the CPU-side access
 * permissions. Assumes the memories answer a forwarded read in the same
 * cycle on mem_rdata_i and that the nonvolatile image is stable at reset.
 */
// Operation
// - Code execution waits after power-on for 0, 1, 2, 4, 8, 16, 32 or 64 ms by the start-up field.
// - Supply code 1 selects dual supply, code 2 single supply, codes 0 and 3 are reserved.
// - The code size byte gives boot plus application code extent in 512-byte blocks.
// - The boot size byte gives the boot section extent in 512-byte blocks.
// - A boot size of zero makes all of flash the boot section regardless of code size.
// - Any lock key other than the valid key locks the device.
// - While locked, debug-port reads of flash, SRAM, EEPROM and fuses are blocked.
// - CPU accesses ignore the lock; CPU may read all and write flash, SRAM, EEPROM, user row, registers.
// - Unlocked, the debug port reads and writes all sections except signature row, which is read only.
// - Locked, the debug port is refused on every section except fuse-write user row writes, user row reads included.
// - A refused debug read still completes, with no error flag, but with data unrelated to memory.
// - Locked, the user row can be written only by the fuse-write command and stays unreadable.
// - Only a full erase from the debugger unlocks; it keeps the user row and clears the rest.
// - The 32-bit key is compared with the fixed pattern 5cc5c55c; a match means unlocked.
`timescale 1ns/100ps
`default_nettype none

module debug_lock_and_boot_fuses
	import lock_fuse_pkg::*;
#(
	parameter int unsigned MS_CYCLES = STARTUP_MS_CYCLES,
	parameter logic [EXTENT_W-1:0] FLASH_BYTES = FLASH_BYTES_DEFAULT
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	// nonvolatile image read at reset
	input wire nv_image_t nv_image_i,
	// debug port access
	input wire mem_req_t dbg_req_i,
	output logic dbg_ack_o,
	output logic [7:0] dbg_rdata_o,
	input wire logic full_erase_cmd_i,
	output logic erase_busy_o,
	// forwarded access towards the memories
	output mem_req_t mem_req_o,
	input wire logic [7:0] mem_rdata_i,
	output logic erase_start_o,
	input wire logic erase_done_i,
	// cpu side
	input wire mem_req_t cpu_req_i,
	output logic cpu_allow_o,
	output logic [7:0] cpu_cfg_rdata_o,
	output logic cpu_run_o,
	// decoded configuration
	output logic locked_o,
	output logic dual_supply_o,
	output logic single_supply_o,
	output logic supply_reserved_o,
	output logic [EXTENT_W-1:0] boot_extent_bytes_o,
	output logic [EXTENT_W-1:0] code_extent_bytes_o
);

	typedef enum logic [1:0] {
		ST_LOAD,
		ST_DELAY,
		ST_RUN,
		ST_ERASE
	} ctl_state_t;

	// reset release through two flops
	logic rst_meta_ff, rst_sync_ff;
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end
	logic rst_n;
	assign rst_n = rst_sync_ff;

	ctl_state_t state_ff, nxt_state;
	logic [31:0] key_ff, nxt_key;
	logic [7:0] sup_cfg_ff, nxt_sup_cfg;
	logic [7:0] code_blk_ff, nxt_code_blk;
	logic [7:0] boot_blk_ff, nxt_boot_blk;
	logic [7:0] dbg_rdata_ff, nxt_dbg_rdata;
	logic [7:0] cpu_rdata_ff, nxt_cpu_rdata;
	logic [EXTENT_W-1:0] boot_ext_ff, nxt_boot_ext;
	logic [EXTENT_W-1:0] code_ext_ff, nxt_code_ext;
	logic erase_start_ff, nxt_erase_start;
	logic delay_start;
	logic delay_done;
	logic locked;
	logic dbg_serve;
	logic dbg_rd_ok;
	logic dbg_wr_ok;
	logic dbg_internal;
	logic [7:0] dbg_local_data;
	logic [7:0] cpu_local_data;
	logic [2:0] startup_delay_sel;
	logic [1:0] supply_arrangement_sel;

	assign startup_delay_sel = nv_image_i.startup_and_supply_config[STARTUP_DELAY_SEL_LSB +: 3];
	assign supply_arrangement_sel = sup_cfg_ff[SUPPLY_ARRANGEMENT_SEL_LSB +: 2];

	assign locked = (key_ff != LOCK_KEY_VALID);

	// the delay timer is started by the load state, with the fresh fuse value
	assign delay_start = (state_ff == ST_LOAD);

	startup_delay_timer #(
		.MS_CYCLES(MS_CYCLES)
	) u_startup (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_n),
		.start_i(delay_start),
		.sel_i(startup_delay_sel),
		.done_o(delay_done)
	);

	// debug access is held off while loading and during an erase
	assign dbg_serve = dbg_req_i.valid && ((state_ff == ST_DELAY) || (state_ff == ST_RUN));

	// debug read permission
	always_comb begin
		dbg_rd_ok = 1'b0;
		if (!locked) begin
			dbg_rd_ok = 1'b1;
		end else begin
			dbg_rd_ok = 1'b0;
		end
	end

	// debug write permission
	always_comb begin
		dbg_wr_ok = 1'b0;
		if (!locked) begin
			dbg_wr_ok = (dbg_req_i.section != SEC_SIGNATURE_ROW);
		end else begin
			dbg_wr_ok = (dbg_req_i.section == SEC_USER_ROW_A) && dbg_req_i.fuse_write_cmd;
		end
	end

	// lock key bytes and the decoded fuse bytes are answered from the shadows
	always_comb begin
		dbg_internal = 1'b0;
		dbg_local_data = 8'h00;
		if (dbg_req_i.section == SEC_LOCK && dbg_req_i.addr[7:0] <= OFS_LOCK_KEY_B3) begin
			dbg_internal = 1'b1;
			dbg_local_data = key_ff[{dbg_req_i.addr[1:0], 3'h0} +: 8];
		end else if (dbg_req_i.section == SEC_FUSE) begin
			unique case (dbg_req_i.addr[7:0])
				OFS_STARTUP_AND_SUPPLY_CONFIG: begin
					dbg_internal = 1'b1;
					dbg_local_data = sup_cfg_ff & SUP_CFG_USED_MASK;
				end
				OFS_CODE_SECTION_SIZE: begin
					dbg_internal = 1'b1;
					dbg_local_data = code_blk_ff;
				end
				OFS_BOOT_SECTION_SIZE: begin
					dbg_internal = 1'b1;
					dbg_local_data = boot_blk_ff;
				end
				default: begin
					dbg_internal = 1'b0;
				end
			endcase
		end
	end

	// cpu side reading of the same configuration bytes
	always_comb begin
		cpu_local_data = 8'h00;
		if (cpu_req_i.section == SEC_LOCK && cpu_req_i.addr[7:0] <= OFS_LOCK_KEY_B3) begin
			cpu_local_data = key_ff[{cpu_req_i.addr[1:0], 3'h0} +: 8];
		end else if (cpu_req_i.section == SEC_FUSE) begin
			unique case (cpu_req_i.addr[7:0])
				OFS_STARTUP_AND_SUPPLY_CONFIG: cpu_local_data = sup_cfg_ff & SUP_CFG_USED_MASK;
				OFS_CODE_SECTION_SIZE: cpu_local_data = code_blk_ff;
				OFS_BOOT_SECTION_SIZE: cpu_local_data = boot_blk_ff;
				default: cpu_local_data = 8'h00;
			endcase
		end
	end

	// cpu permission does not look at the lock at all
	always_comb begin
		if (!cpu_req_i.write) begin
			cpu_allow_o = cpu_req_i.valid;
		end else begin
			unique case (cpu_req_i.section)
				SEC_SIGNATURE_ROW, SEC_FUSE, SEC_LOCK: cpu_allow_o = 1'b0;
				default: cpu_allow_o = cpu_req_i.valid;
			endcase
		end
	end

	// forward only granted debug traffic, so a refused write never lands
	always_comb begin
		mem_req_o = dbg_req_i;
		mem_req_o.valid = 1'b0;
		if (dbg_serve) begin
			if (dbg_req_i.write) begin
				mem_req_o.valid = dbg_wr_ok;
			end else begin
				mem_req_o.valid = dbg_rd_ok && !dbg_internal;
			end
		end
	end

	assign dbg_ack_o = dbg_serve;

	// main control: load, delay, run, erase
	always_comb begin
		nxt_state = state_ff;
		nxt_key = key_ff;
		nxt_sup_cfg = sup_cfg_ff;
		nxt_code_blk = code_blk_ff;
		nxt_boot_blk = boot_blk_ff;
		nxt_erase_start = 1'b0;
		nxt_dbg_rdata = dbg_rdata_ff;
		unique case (state_ff)
			ST_LOAD: begin
				nxt_key = nv_image_i.lock_key;
				nxt_sup_cfg = nv_image_i.startup_and_supply_config;
				nxt_code_blk = nv_image_i.code_extent_blocks;
				nxt_boot_blk = nv_image_i.boot_extent_blocks;
				nxt_state = ST_DELAY;
			end
			ST_DELAY: begin
				if (delay_done) begin
					nxt_state = ST_RUN;
				end
			end
			ST_RUN: begin
				nxt_state = ST_RUN;
			end
			ST_ERASE: begin
				// the erase wipes the key to the valid pattern in the array as well
				if (erase_done_i) begin
					nxt_key = LOCK_KEY_VALID;
					nxt_state = ST_RUN;
				end
			end
		endcase
		// erase is the only exit from the locked state; accepted when locked or not
		if ((state_ff == ST_DELAY || state_ff == ST_RUN) && full_erase_cmd_i) begin
			nxt_erase_start = 1'b1;
			nxt_state = ST_ERASE;
		end
		if (dbg_serve && !dbg_req_i.write) begin
			if (!dbg_rd_ok) begin
				nxt_dbg_rdata = 8'h00;
			end else if (dbg_internal) begin
				nxt_dbg_rdata = dbg_local_data;
			end else begin
				nxt_dbg_rdata = mem_rdata_i;
			end
		end
		// a debug write of the key takes effect on the port at once
		if (mem_req_o.valid && dbg_req_i.write && dbg_req_i.section == SEC_LOCK
				&& dbg_req_i.addr[7:0] <= OFS_LOCK_KEY_B3) begin
			nxt_key[{dbg_req_i.addr[1:0], 3'h0} +: 8] = dbg_req_i.wdata;
		end
	end

	// section extents in bytes, wide enough for 255 blocks of 512
	always_comb begin
		nxt_code_ext = EXTENT_W'({code_blk_ff, {BLOCK_SHIFT{1'b0}}});
		nxt_boot_ext = EXTENT_W'({boot_blk_ff, {BLOCK_SHIFT{1'b0}}});
		if (boot_blk_ff == 8'h00) begin
			nxt_boot_ext = FLASH_BYTES;
			nxt_code_ext = FLASH_BYTES;
		end
		nxt_cpu_rdata = cpu_local_data;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= ST_LOAD;
			key_ff <= KEY_SHADOW_RESET;
			sup_cfg_ff <= SHADOW_RESET;
			code_blk_ff <= SHADOW_RESET;
			boot_blk_ff <= SHADOW_RESET;
			erase_start_ff <= 1'b0;
			dbg_rdata_ff <= 8'h00;
			cpu_rdata_ff <= 8'h00;
			boot_ext_ff <= '0;
			code_ext_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			key_ff <= nxt_key;
			sup_cfg_ff <= nxt_sup_cfg;
			code_blk_ff <= nxt_code_blk;
			boot_blk_ff <= nxt_boot_blk;
			erase_start_ff <= nxt_erase_start;
			dbg_rdata_ff <= nxt_dbg_rdata;
			cpu_rdata_ff <= nxt_cpu_rdata;
			boot_ext_ff <= nxt_boot_ext;
			code_ext_ff <= nxt_code_ext;
		end
	end

	assign dbg_rdata_o = dbg_rdata_ff;
	assign cpu_cfg_rdata_o = cpu_rdata_ff;
	assign erase_start_o = erase_start_ff;
	assign erase_busy_o = (state_ff == ST_ERASE);
	// the cpu is held through the delay and through an erase
	assign cpu_run_o = (state_ff == ST_RUN);
	// the reset value of the shadow key reads as locked until the load is done
	assign locked_o = locked;
	assign dual_supply_o = (supply_arrangement_sel == SUPPLY_DUAL);
	assign single_supply_o = (supply_arrangement_sel == SUPPLY_SINGLE);
	assign supply_reserved_o = !dual_supply_o && !single_supply_o;
	assign boot_extent_bytes_o = boot_ext_ff;
	assign code_extent_bytes_o = code_ext_ff;

endmodule : debug_lock_and_boot_fuses

`default_nettype wire

// ### logic/lock_fuse_pkg.sv
/*
 * Constants, enumerations and carrier structs shared by the boot fuse and
 * debug lock logic. Assumes a single 25 MHz system clock.
 */
package lock_fuse_pkg;

	// system clock
	localparam int unsigned CLK_PERIOD_NS = 40;

	// start-up delay unit: one millisecond
	localparam int unsigned STARTUP_UNIT_MS = 1;
	localparam int unsigned STARTUP_MS_CYCLES = (STARTUP_UNIT_MS * 1000000) / CLK_PERIOD_NS;
	localparam int unsigned STARTUP_SEL_W = 3;
	localparam int unsigned STARTUP_MS_W = 7;

	// byte offsets of the lock key inside the lock section
	localparam logic [7:0] OFS_LOCK_KEY_B0 = 8'h00;
	localparam logic [7:0] OFS_LOCK_KEY_B3 = 8'h03;

	// byte offsets inside the fuse section
	localparam logic [7:0] OFS_STARTUP_AND_SUPPLY_CONFIG = 8'h06;
	localparam logic [7:0] OFS_CODE_SECTION_SIZE = 8'h07;
	localparam logic [7:0] OFS_BOOT_SECTION_SIZE = 8'h08;

	// startup_and_supply_config field layout
	localparam int unsigned STARTUP_DELAY_SEL_LSB = 0;
	localparam int unsigned SUPPLY_ARRANGEMENT_SEL_LSB = 3;
	localparam logic [7:0] SUP_CFG_USED_MASK = 8'h1f;

	// supply arrangement codes
	localparam logic [1:0] SUPPLY_DUAL = 2'h1;
	localparam logic [1:0] SUPPLY_SINGLE = 2'h2;

	// the one key value that leaves the port unlocked
	localparam logic [31:0] LOCK_KEY_VALID = 32'h5cc5c55c;

	// section sizes are counted in 512-byte blocks
	localparam int unsigned BLOCK_SHIFT = 9;
	localparam int unsigned EXTENT_W = 17;
	localparam logic [EXTENT_W-1:0] FLASH_BYTES_DEFAULT = 17'h10000;

	// reset value of every shadow byte before the nonvolatile load
	localparam logic [7:0] SHADOW_RESET = 8'h00;
	localparam logic [31:0] KEY_SHADOW_RESET = 32'h00000000;

	typedef enum logic [2:0] {
		SEC_FLASH,
		SEC_SRAM,
		SEC_EEPROM,
		SEC_SIGNATURE_ROW,
		SEC_USER_ROW_A,
		SEC_FUSE,
		SEC_LOCK,
		SEC_REGS
	} mem_section_t;

	// one access request, from the debug port or towards the memories
	typedef struct packed {
		logic valid;
		logic write;
		logic fuse_write_cmd;
		mem_section_t section;
		logic [15:0] addr;
		logic [7:0] wdata;
	} mem_req_t;

	// nonvolatile contents presented at reset initialisation
	typedef struct packed {
		logic [31:0] lock_key;
		logic [7:0] startup_and_supply_config;
		logic [7:0] code_extent_blocks;
		logic [7:0] boot_extent_blocks;
	} nv_image_t;

endpackage : lock_fuse_pkg

// ### logic/startup_delay_timer.sv
/*
 * Start-up delay timer: counts 0 to 64 milliseconds after a start pulse.
 * Assumes start_i is a one-cycle pulse and sel_i is stable while counting.
 */
`timescale 1ns/100ps
`default_nettype none

module startup_delay_timer
	import lock_fuse_pkg::*;
#(
	parameter int unsigned MS_CYCLES = STARTUP_MS_CYCLES
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	// control
	input wire logic start_i,
	input wire logic [STARTUP_SEL_W-1:0] sel_i,
	// status
	output logic done_o
);

	localparam int unsigned CYC_W = $clog2(MS_CYCLES + 1);

	logic busy_ff, nxt_busy;
	logic done_ff, nxt_done;
	logic [CYC_W-1:0] cyc_ff, nxt_cyc;
	logic [STARTUP_MS_W-1:0] ms_ff, nxt_ms;
	logic [STARTUP_MS_W-1:0] ms_target;

	// code 0 means no delay, code n means 2^(n-1) ms
	always_comb begin
		if (sel_i == '0) begin
			ms_target = '0;
		end else begin
			ms_target = STARTUP_MS_W'(1) << (sel_i - STARTUP_SEL_W'(1));
		end
	end

	always_comb begin
		nxt_busy = busy_ff;
		nxt_done = done_ff;
		nxt_cyc = cyc_ff;
		nxt_ms = ms_ff;
		if (start_i) begin
			nxt_cyc = '0;
			nxt_ms = '0;
			nxt_busy = (ms_target != '0);
			nxt_done = (ms_target == '0);
		end else if (busy_ff) begin
			if (cyc_ff == CYC_W'(MS_CYCLES - 1)) begin
				nxt_cyc = '0;
				nxt_ms = ms_ff + STARTUP_MS_W'(1);
				if (nxt_ms == ms_target) begin
					nxt_busy = 1'b0;
					nxt_done = 1'b1;
				end
			end else begin
				nxt_cyc = cyc_ff + CYC_W'(1);
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			cyc_ff <= '0;
			ms_ff <= '0;
		end else begin
			busy_ff <= nxt_busy;
			done_ff <= nxt_done;
			cyc_ff <= nxt_cyc;
			ms_ff <= nxt_ms;
		end
	end

	assign done_o = done_ff;

endmodule : startup_delay_timer

`default_nettype wire

// ### test/debug_lock_and_boot_fuses_test.sv
/*
 * Self-checking bench of the lock and fuse block with a memory model.
 * Assumes a 25 MHz clock and a shortened millisecond count.
 */
`timescale 1ns/100ps
`default_nettype none

module debug_lock_and_boot_fuses_test;
	import lock_fuse_pkg::*;
	localparam int unsigned MSC = 4;
	logic clk_sys_i = 1'b0;
	logic rst_b_i = 1'b0;
	nv_image_t nv = '0;
	nv_image_t img;
	mem_req_t dq = '0;
	mem_req_t cq = '0;
	mem_req_t mq;
	logic fe = 1'b0;
	logic [7:0] mrd, drd, crd;
	logic ack, busy, est, edn, allow, run, lck, du, si, rs;
	logic [EXTENT_W-1:0] bx, cx;
	logic [31:0] seed = 32'h0000c10b;
	int checks = 0;
	int fail_count = 0;
	int i, j;
	mem_section_t s;

	debug_lock_and_boot_fuses #(.MS_CYCLES(MSC)) i_dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
		.nv_image_i(nv), .dbg_req_i(dq), .dbg_ack_o(ack), .dbg_rdata_o(drd),
		.full_erase_cmd_i(fe), .erase_busy_o(busy), .mem_req_o(mq), .mem_rdata_i(mrd),
		.erase_start_o(est), .erase_done_i(edn), .cpu_req_i(cq), .cpu_allow_o(allow),
		.cpu_cfg_rdata_o(crd), .cpu_run_o(run), .locked_o(lck), .dual_supply_o(du),
		.single_supply_o(si), .supply_reserved_o(rs), .boot_extent_bytes_o(bx),
		.code_extent_bytes_o(cx));
	mem_model i_mem (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .mem_req_i(mq),
		.mem_rdata_o(mrd), .erase_start_i(est), .erase_done_o(edn));

	initial begin
		forever #20 clk_sys_i = ~clk_sys_i;
	end

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function logic [EXTENT_W-1:0] ext(input logic [7:0] b, input logic [7:0] n);
		return b == 8'h00 ? FLASH_BYTES_DEFAULT : {n, 9'h000};
	endfunction : ext

	task end_sim();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_sim

	task check(input logic [31:0] seen, input logic [31:0] exp, input string nm);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task boot(input logic [2:0] sel);
		int n, d;
		d = sel == 3'h0 ? 0 : (1 << (sel - 1)) * MSC;
		@(negedge clk_sys_i);
		rst_b_i = 1'b0;
		nv = img;
		repeat (16) @(negedge clk_sys_i);
		rst_b_i = 1'b1;
		n = 0;
		while (run !== 1'b1 && n < 400) begin
			@(negedge clk_sys_i);
			n++;
		end
		check(n >= d && n <= d + 6, 1, "startup");
		if (n == 400)
			end_sim();
	endtask : boot

	task dbg(input mem_section_t sc, input logic w, input logic f, input logic [15:0] a,
		input logic [7:0] wd, input logic fwd, input logic [7:0] rd);
		@(negedge clk_sys_i);
		dq = '{1'b1, w, f, sc, a, wd};
		#1;
		check(ack, 1, "ack");
		check(mq.valid, fwd, "forward");
		@(negedge clk_sys_i);
		dq.valid = 1'b0;
		if (!w)
			check(drd, rd, "rdata");
	endtask : dbg

	initial begin
		for (i = 0; i < 8; i++) begin
			img.lock_key = (i == 2 || i == 5) ? LOCK_KEY_VALID : rnd();
			img.startup_and_supply_config = {rnd() & 8'he0} | {i[1:0], i[2:0]};
			img.code_extent_blocks = rnd();
			img.boot_extent_blocks = i[0] ? rnd() : 8'h00;
			boot(i);
			check(lck, img.lock_key != LOCK_KEY_VALID, "locked");
			check({du, si, rs}, {i[1:0] == 2'h1, i[1:0] == 2'h2, i[0] == i[1]}, "supply");
			check(bx, ext(img.boot_extent_blocks, img.boot_extent_blocks), "boot");
			check(cx, ext(img.boot_extent_blocks, img.code_extent_blocks), "code");
			for (j = 0; j < 16; j++) begin
				@(negedge clk_sys_i);
				cq = '{1'b1, j[0], 1'b0, mem_section_t'(j[3:1]), 16'h0002, 8'h00};
				#1;
				check(allow, !j[0] || !(j[3:1] inside {3, 5, 6}), "cpu");
				@(negedge clk_sys_i);
				if (j == 12)
					check(crd, img.lock_key[23:16], "cpu key");
			end
			cq.valid = 1'b0;
		end
		for (j = 0; j < 8; j++) begin
			s = mem_section_t'(j);
			dbg(s, 0, 0, 16'h0010 + j, 8'h00, 0, 8'h00);
			dbg(s, 1, 0, 16'h0010 + j, rnd(), 0, 8'h00);
		end
		dbg(SEC_USER_ROW_A, 1, 1, 16'h0004, rnd(), 1, 8'h00);
		dbg(SEC_FLASH, 1, 1, 16'h0004, rnd(), 0, 8'h00);
		@(negedge clk_sys_i);
		fe = 1'b1;
		@(negedge clk_sys_i);
		fe = 1'b0;
		dq.valid = 1'b1;
		#1;
		check({est, busy, ack}, 3'b110, "erase start");
		@(negedge clk_sys_i);
		dq.valid = 1'b0;
		for (j = 0; j < 50 && busy !== 1'b0; j++)
			@(negedge clk_sys_i);
		if (j == 50) begin
			fail_count++;
			end_sim();
		end
		check({lck, run}, 2'b01, "erase end");
		for (j = 0; j < 8; j++) begin
			s = mem_section_t'(j);
			dbg(s, 0, 0, 16'h0010 + j, 8'h00, 1, 8'h4a ^ j);
			dbg(s, 1, 0, 16'h0010 + j, rnd(), s != SEC_SIGNATURE_ROW, 8'h00);
		end
		dbg(SEC_FUSE, 0, 0, 16'h0006, 8'h00, 0, img.startup_and_supply_config & 8'h1f);
		dbg(SEC_FUSE, 0, 0, 16'h0007, 8'h00, 0, img.code_extent_blocks);
		dbg(SEC_FUSE, 0, 0, 16'h0008, 8'h00, 0, img.boot_extent_blocks);
		for (j = 0; j < 4; j++)
			dbg(SEC_LOCK, 0, 0, j, 8'h00, 0, LOCK_KEY_VALID[8 * j +: 8]);
		dbg(SEC_LOCK, 1, 0, 16'h0000, 8'h00, 1, 8'h00);
		check(lck, 1, "relock");
		end_sim();
	end
endmodule : debug_lock_and_boot_fuses_test

`default_nettype wire

// ### test/lock_fuse_checker.sv
/*
 * Assertions on the top ports of the lock and fuse block.
 * Assumes the nonvolatile image stays stable while running.
 */
`timescale 1ns/100ps
`default_nettype none

module lock_fuse_checker
	import lock_fuse_pkg::*;
#(
	parameter logic [EXTENT_W-1:0] FLASH_BYTES = FLASH_BYTES_DEFAULT
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	// debug and memory side
	input wire nv_image_t nv_image_i,
	input wire mem_req_t dbg_req_i,
	input wire logic dbg_ack_o,
	input wire logic [7:0] dbg_rdata_o,
	input wire logic full_erase_cmd_i,
	input wire logic erase_busy_o,
	input wire mem_req_t mem_req_o,
	input wire logic erase_start_o,
	input wire logic erase_done_i,
	// cpu side and decode
	input wire mem_req_t cpu_req_i,
	input wire logic cpu_allow_o,
	input wire logic cpu_run_o,
	input wire logic locked_o,
	input wire logic dual_supply_o,
	input wire logic single_supply_o,
	input wire logic supply_reserved_o,
	input wire logic [EXTENT_W-1:0] boot_extent_bytes_o,
	input wire logic [EXTENT_W-1:0] code_extent_bytes_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);

	logic [1:0] sup;
	logic [7:0] bt;
	logic lwr;
	logic uwr;
	assign sup = nv_image_i.startup_and_supply_config[4:3];
	assign bt = nv_image_i.boot_extent_blocks;
	assign lwr = dbg_ack_o && dbg_req_i.write && locked_o;
	assign uwr = dbg_req_i.section == SEC_USER_ROW_A && dbg_req_i.fuse_write_cmd;

	sequence s_erase_go;
		full_erase_cmd_i && cpu_run_o;
	endsequence
	sequence s_erase_on;
		erase_start_o && erase_busy_o && !cpu_run_o;
	endsequence

	property p_rd_lock;
		dbg_ack_o && !dbg_req_i.write && locked_o |=> dbg_rdata_o == 8'h00;
	endproperty
	property p_wr_lock;
		lwr && !uwr |-> !mem_req_o.valid;
	endproperty
	property p_user_wr;
		lwr && uwr |-> mem_req_o.valid;
	endproperty
	property p_sig_wr;
		dbg_ack_o && dbg_req_i.write && !locked_o
			&& dbg_req_i.section == SEC_SIGNATURE_ROW |-> !mem_req_o.valid;
	endproperty
	property p_cpu;
		cpu_allow_o == (cpu_req_i.valid && (!cpu_req_i.write
			|| !(cpu_req_i.section inside {SEC_SIGNATURE_ROW, SEC_FUSE, SEC_LOCK})));
	endproperty
	property p_supply;
		cpu_run_o |-> dual_supply_o == (sup == 2'h1) && single_supply_o == (sup == 2'h2)
			&& supply_reserved_o == (sup == 2'h0 || sup == 2'h3);
	endproperty
	property p_extent;
		cpu_run_o |-> boot_extent_bytes_o == (bt == 8'h00 ? FLASH_BYTES : {bt, 9'h000})
			&& code_extent_bytes_o == (bt == 8'h00 ? FLASH_BYTES
			: {nv_image_i.code_extent_blocks, 9'h000});
	endproperty
	property p_lock_init;
		$rose(cpu_run_o) && !$past(erase_busy_o)
			|-> locked_o == (nv_image_i.lock_key != LOCK_KEY_VALID);
	endproperty
	property p_erase;
		s_erase_go |=> s_erase_on;
	endproperty
	property p_done;
		erase_busy_o && erase_done_i |=> !erase_busy_o && !locked_o && cpu_run_o;
	endproperty

	a_rd_lock: assert property (p_rd_lock) else $error("locked read returned data");
	a_wr_lock: assert property (p_wr_lock) else $error("locked write forwarded");
	a_user_wr: assert property (p_user_wr) else $error("user row write dropped");
	a_sig_wr: assert property (p_sig_wr) else $error("signature write forwarded");
	a_cpu: assert property (p_cpu) else $error("cpu permission wrong");
	a_supply: assert property (p_supply) else $error("supply decode wrong");
	a_extent: assert property (p_extent) else $error("extent wrong");
	a_lock_init: assert property (p_lock_init) else $error("lock state wrong");
	a_erase: assert property (p_erase) else $error("erase not started");
	a_done: assert property (p_done) else $error("erase did not unlock");
endmodule : lock_fuse_checker

bind debug_lock_and_boot_fuses lock_fuse_checker #(.FLASH_BYTES(FLASH_BYTES)) i_chk (
	.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .nv_image_i(nv_image_i),
	.dbg_req_i(dbg_req_i), .dbg_ack_o(dbg_ack_o), .dbg_rdata_o(dbg_rdata_o),
	.full_erase_cmd_i(full_erase_cmd_i), .erase_busy_o(erase_busy_o),
	.mem_req_o(mem_req_o), .erase_start_o(erase_start_o), .erase_done_i(erase_done_i),
	.cpu_req_i(cpu_req_i), .cpu_allow_o(cpu_allow_o), .cpu_run_o(cpu_run_o),
	.locked_o(locked_o), .dual_supply_o(dual_supply_o), .single_supply_o(single_supply_o),
	.supply_reserved_o(supply_reserved_o), .boot_extent_bytes_o(boot_extent_bytes_o),
	.code_extent_bytes_o(code_extent_bytes_o));

`default_nettype wire

// ### test/mem_model.sv
/*
 * Memory and erase-controller side of the lock block.
 * Assumes one system clock and the reset of the block.
 */
`timescale 1ns/100ps
`default_nettype none

module mem_model
	import lock_fuse_pkg::*;
#(
	parameter int unsigned ERASE_CYCLES = 5
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	// memory access
	input wire mem_req_t mem_req_i,
	output logic [7:0] mem_rdata_o,
	// erase
	input wire logic erase_start_i,
	output logic erase_done_o
);
	logic [7:0] noise_ff;
	logic [3:0] cnt_ff;

	// idle bus changes every cycle so stale data never looks valid
	assign mem_rdata_o = mem_req_i.valid ? (mem_req_i.addr[7:0] ^ 8'h5a) : noise_ff;
	assign erase_done_o = (cnt_ff == 4'h1);

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			noise_ff <= 8'h00;
			cnt_ff <= 4'h0;
		end else begin
			noise_ff <= noise_ff + 8'h3b;
			if (erase_start_i)
				cnt_ff <= 4'(ERASE_CYCLES);
			else if (cnt_ff != 4'h0)
				cnt_ff <= cnt_ff - 4'h1;
		end
	end
endmodule : mem_model

`default_nettype wire
